// File: hdl/stp_command_port.sv
`include "stp_params.svh"
module stp_command_port #(
  parameter int unsigned BIT_CYCLES = `STP_BIT_CYCLES,
  parameter int unsigned MS_CYCLES  = `STP_MS_CYCLES
) (
  input  wire logic        hclk,        // Bus clock, 100 MHz
  input  wire logic        hresetn,     // Async reset, active low
  input  wire logic        hsel,        // Slave select
  input  wire logic [31:0] haddr,       // Byte address
  input  wire logic [1:0]  htrans,      // Transfer type
  input  wire logic        hwrite,      // Write when high
  input  wire logic [2:0]  hsize,       // Word transfers only
  input  wire logic [31:0] hwdata,      // Write data
  input  wire logic        hready,      // Bus ready
  output logic      [31:0] hrdata,      // Read data
  output logic             hreadyout,   // Always ready
  output logic             hresp,       // Always OKAY
  input  wire logic        rxd,         // Serial receive line
  input  wire logic [6:0]  pin_station, // Station number pins
  output logic             txd,         // Serial transmit line
  output logic             txd_oe_n,    // Driver enable, low drives
  output logic             term_en      // Line termination on
);
  stp_pkg::stp_top_t st;
  stp_pkg::stp_top_t n;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       tx_busy;

  localparam stp_pkg::stp_top_t RST_ST = '{
    state: stp_pkg::ST_IDLE, duplex: `STP_RST_DUPLEX, station: `STP_RST_STATION,
    boot: 2'h1, oe_n: 1'b1, default: '0};

  function automatic logic [7:0] dig(input logic [16:0] v, input logic [2:0] p);
    logic [16:0] q;
    q = v;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(p)) q = q / 17'h0000a;
    end
    return 8'(q % 17'h0000a) + `STP_ZERO;
  endfunction

  function automatic logic is_dig(input logic [7:0] c);
    return (c >= `STP_ZERO) && (c <= `STP_NINE);
  endfunction

  function automatic logic [16:0] dec5(input logic [0:4][7:0] d);
    logic [16:0] v;
    v = 17'h0;
    for (int i = 0; i < 5; i++) begin
      v = 17'(v * 17'h0000a) + {13'h0, d[i][3:0]};
    end
    return v;
  endfunction

  function automatic logic [0:10][7:0] fmt(input logic data_tel, input logic [6:0] stn,
                                           input logic [15:0] code, input logic [16:0] val);
    logic [16:0] s;
    s = {10'h0, stn};
    if (data_tel) begin
      return {dig(s, 3'h1), dig(s, 3'h0), dig(val, 3'h4), dig(val, 3'h3), dig(val, 3'h2),
              dig(val, 3'h1), dig(val, 3'h0), `STP_CR, 24'h0};
    end
    return {`STP_BANG, dig(s, 3'h1), dig(s, 3'h0), code[15:8], code[7:0], dig(val, 3'h4),
            dig(val, 3'h3), dig(val, 3'h2), dig(val, 3'h1), dig(val, 3'h0), `STP_CR};
  endfunction

  function automatic logic [6:0] eff_station(input stp_pkg::stp_top_t s);
    if (s.pin_en && s.duplex == `STP_DPX_HALF && s.pin_val <= 7'(`STP_MAX_STATION)) begin
      return s.pin_val;
    end
    return s.station;
  endfunction

  stp_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .rxd      (rxd),
    .rx_valid (rx_valid),
    .rx_byte  (rx_byte)
  );

  stp_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tx_start (st.tx_start),
    .tx_byte  (st.txbuf[st.txidx]),
    .tx_busy  (tx_busy),
    .txd      (txd)
  );

  logic        rx_cr;
  logic        well_formed;
  logic        addr_hit;
  logic [16:0] param;
  logic [15:0] code;
  assign rx_cr       = rx_valid && rx_byte == `STP_CR;
  assign code        = {st.rxbuf[2], st.rxbuf[3]};
  assign param       = dec5(st.rxbuf[4:8]);
  assign well_formed = is_dig(st.rxbuf[0]) && is_dig(st.rxbuf[1]) &&
                       (st.rxcnt == `STP_LEN_QUERY ||
                        (st.rxcnt == `STP_LEN_SET && is_dig(st.rxbuf[4]) &&
                         is_dig(st.rxbuf[5]) && is_dig(st.rxbuf[6]) &&
                         is_dig(st.rxbuf[7]) && is_dig(st.rxbuf[8])));
  assign addr_hit    = 7'(st.rxbuf[0][3:0] * 4'ha) + {3'h0, st.rxbuf[1][3:0]} ==
                       eff_station(st);

  always_comb begin
    logic        tick;
    logic        take;
    logic        set;
    logic        data_tel;
    logic [5:0]  err;
    logic [16:0] val;
    tick     = st.ms_cnt == 17'(MS_CYCLES - 1);
    take     = rx_cr && st.state == stp_pkg::ST_IDLE && well_formed && addr_hit;
    set      = st.rxcnt == `STP_LEN_SET;
    data_tel = 1'b0;
    err      = 6'h0;
    val      = 17'h0;
    n = st;
    n.tx_start = 1'b0;
    n.ps0 = pin_station;
    n.ps1 = st.ps0;
    n.ps2 = st.ps1;
    if (st.ps1 == st.ps2) n.pin_val = st.ps2;
    n.ms_cnt = tick ? 17'h0 : st.ms_cnt + 17'h1;
    if (tick && !st.min_done) begin
      n.min_ms = st.min_ms + 16'h1;
      if (n.min_ms == `STP_MINUTE_MS) n.min_done = 1'b1;
    end
    if (tick && st.state == stp_pkg::ST_DELAY && st.dly_ms != 16'h0) begin
      n.dly_ms = st.dly_ms - 16'h1;
    end
    if (tick && st.auto_ms != 16'hffff) n.auto_ms = st.auto_ms + 16'h1;

    // Register writes land in the data phase
    n.wr_pend = hsel && hready && htrans[1] && hwrite;
    n.wr_addr = haddr[7:0];
    if (st.wr_pend) begin
      unique case (st.wr_addr)
        `STP_OFF_CTRL: begin
          if (hwdata[1:0] <= `STP_DPX_P2P) n.duplex = hwdata[1:0];
          n.term     = hwdata[2];
          n.pin_en   = hwdata[3];
          n.min_ms   = 16'h0;
          n.min_done = 1'b0;
        end
        `STP_OFF_STATION: begin
          if (hwdata <= 32'(`STP_MAX_STATION)) n.station = hwdata[6:0];
        end
        `STP_OFF_RDELAY: n.reply_dly = hwdata[15:0];
        `STP_OFF_AUTOPER: begin
          n.auto_per = hwdata[15:0];
          n.min_ms   = 16'h0;
          n.min_done = 1'b0;
        end
        `STP_OFF_DATA: n.data_val = hwdata[16:0];
        default: ;
      endcase
    end

    // Receive buffer; a carriage return always empties it
    if (rx_valid) begin
      if (rx_cr) n.rxcnt = 4'h0;
      else if (st.rxcnt < `STP_LEN_SET) begin
        n.rxbuf[st.rxcnt] = rx_byte;
        n.rxcnt = st.rxcnt + 4'h1;
      end else n.rxcnt = `STP_LEN_OVF;
    end

    unique case (st.state)
      stp_pkg::ST_IDLE: begin
        if (take) begin
          case (code)
            `STP_CMD_DUPLEX: begin
              if (set) begin
                if (param <= 17'(`STP_DPX_P2P)) begin
                  n.duplex   = param[1:0];
                  n.min_ms   = 16'h0;
                  n.min_done = 1'b0;
                end else err = `STP_ERR_RANGE;
              end
              val = {15'h0, n.duplex};
            end
            `STP_CMD_TERM: begin
              if (set) begin
                if (param <= 17'h1) n.term = param[0];
                else err = `STP_ERR_RANGE;
              end
              val = {16'h0, n.term};
            end
            `STP_CMD_PINSTN: begin
              if (set) begin
                if (param > 17'h1) err = `STP_ERR_RANGE;
                else if (param[0] && st.duplex != `STP_DPX_HALF) err = `STP_ERR_CONFLICT;
                else n.pin_en = param[0];
              end
              val = {16'h0, n.pin_en};
            end
            `STP_CMD_BAUD: begin
              if (set) err = `STP_ERR_ACCESS;
              val = `STP_BAUD_SEL;
            end
            `STP_CMD_STNID: begin
              if (set) begin
                if (param <= `STP_MAX_STATION) n.station = param[6:0];
                else err = `STP_ERR_RANGE;
              end
              val = {10'h0, n.station};
            end
            `STP_CMD_TREQ: data_tel = 1'b1;
            `STP_CMD_TAUTO: begin
              if (set) begin
                if (param <= `STP_MAX_U16) begin
                  n.auto_per = param[15:0];
                  n.min_ms   = 16'h0;
                  n.min_done = 1'b0;
                end else err = `STP_ERR_RANGE;
              end
              data_tel = 1'b1;
            end
            default: err = `STP_ERR_ACCESS;
          endcase
          if (err != 6'h0) begin
            n.txbuf = fmt(1'b0, eff_station(n), `STP_CMD_ERROR, {11'h0, err});
            n.txlen = `STP_LEN_ACK;
          end else if (data_tel) begin
            n.txbuf = fmt(1'b1, eff_station(n), code, st.data_val);
            n.txlen = `STP_LEN_DATA;
          end else begin
            n.txbuf = fmt(1'b0, eff_station(n), code, val);
            n.txlen = `STP_LEN_ACK;
          end
          n.last_err = err;
          n.state    = stp_pkg::ST_DELAY;
          n.dly_ms   = st.reply_dly;
          n.ms_cnt   = 17'h0;
          n.txidx    = 4'h0;
          n.auto_tx  = 1'b0;
        end else if (st.boot != 2'h0) begin
          // Baud first, then duplex, both at the fixed startup rate
          n.txbuf = (st.boot == 2'h1) ?
                    fmt(1'b0, eff_station(st), `STP_CMD_BAUD, `STP_BAUD_SEL) :
                    fmt(1'b0, eff_station(st), `STP_CMD_DUPLEX, {15'h0, st.duplex});
          n.boot  = (st.boot == 2'h1) ? 2'h2 : 2'h0;
          n.txlen = `STP_LEN_ACK;
          n.txidx = 4'h0;
          n.state = stp_pkg::ST_SEND;
        end else if (st.auto_per != 16'h0 && st.auto_ms >= st.auto_per &&
                     (st.min_done || st.duplex != `STP_DPX_HALF)) begin
          n.txbuf   = fmt(1'b1, eff_station(st), `STP_CMD_TAUTO, st.data_val);
          n.txlen   = `STP_LEN_DATA;
          n.txidx   = 4'h0;
          n.auto_tx = 1'b1;
          n.auto_ms = 16'h0;
          n.state   = stp_pkg::ST_SEND;
        end
      end
      stp_pkg::ST_DELAY: begin
        if (st.dly_ms == 16'h0) n.state = stp_pkg::ST_SEND;
      end
      stp_pkg::ST_SEND: begin
        if (!tx_busy && !st.tx_start) begin
          if (st.txidx == st.txlen) n.state = stp_pkg::ST_IDLE;
          else begin
            n.tx_start = 1'b1;
            n.txidx    = st.txidx + 4'h1;
          end
        end
      end
    endcase
    // Tx byte index advances with the start pulse, so present the current one
    if (n.tx_start) n.txidx = st.txidx;
    if (st.tx_start) n.txidx = st.txidx + 4'h1;

    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        `STP_OFF_CTRL:    n.hrdata = {28'h0, n.pin_en, n.term, n.duplex};
        `STP_OFF_STATION: n.hrdata = {25'h0, n.station};
        `STP_OFF_RDELAY:  n.hrdata = {16'h0, n.reply_dly};
        `STP_OFF_AUTOPER: n.hrdata = {16'h0, n.auto_per};
        `STP_OFF_DATA:    n.hrdata = {15'h0, n.data_val};
        `STP_OFF_STATUS:  n.hrdata = {9'h0, eff_station(n), 4'h0, n.rxcnt, n.last_err,
                                      n.min_done, n.state != stp_pkg::ST_IDLE};
        default:          n.hrdata = 32'h0;
      endcase
    end
    n.oe_n     = !(st.duplex == `STP_DPX_P2P || st.state == stp_pkg::ST_SEND);
    n.term_out = st.term && st.duplex == `STP_DPX_HALF;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) st <= RST_ST;
    else st <= n;
  end

  // Index fix-up above keeps txidx pointing at the byte being started
  assign hrdata    = st.hrdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign txd_oe_n  = st.oe_n;
  assign term_en   = st.term_out;

  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_reply_built;
    st.state == stp_pkg::ST_IDLE ##1 st.state == stp_pkg::ST_DELAY;
  endsequence

  p2p_drive_on_a: assert property (st.duplex == `STP_DPX_P2P |=> !txd_oe_n)
    else $error("driver off in point-to-point mode");
  bus_release_a: assert property (st.duplex != `STP_DPX_P2P && st.state != stp_pkg::ST_SEND
                                  |=> txd_oe_n)
    else $error("driver on outside transmission");
  delay_silent_a: assert property (st.state == stp_pkg::ST_DELAY |-> !tx_busy && !st.tx_start)
    else $error("transmission during reply delay");
  ack_format_a: assert property (s_reply_built ##0 st.txlen == `STP_LEN_ACK
                                 |-> st.txbuf[0] == `STP_BANG && st.txbuf[10] == `STP_CR)
    else $error("acknowledge framing wrong");
  cr_flush_a: assert property (rx_cr |=> st.rxcnt == 4'h0)
    else $error("buffer not emptied by carriage return");
  foreign_quiet_a: assert property (rx_cr && st.state == stp_pkg::ST_IDLE && !addr_hit
                                    && st.boot == 2'h0 |=> st.state != stp_pkg::ST_DELAY)
    else $error("reply to foreign station");
  minute_gate_a: assert property ($rose(st.auto_tx) && st.duplex == `STP_DPX_HALF
                                  |-> $past(st.min_done))
    else $error("autosend before the minute elapsed");
  err_reason_a: assert property (s_reply_built ##0 st.last_err != 6'h0 |->
                                 st.last_err inside {`STP_ERR_ACCESS, `STP_ERR_RANGE,
                                 `STP_ERR_CONFLICT})
    else $error("bad error reason");
  pin_station_a: assert property (st.duplex != `STP_DPX_HALF |-> eff_station(st) == st.station)
    else $error("pin station used in full duplex");
  term_gate_a: assert property (st.duplex != `STP_DPX_HALF |=> !term_en)
    else $error("termination on outside half duplex");
  boot_order_a: assert property ($fell(st.boot == 2'h1) |-> st.txbuf[3] == 8'h42 ##1
                                 st.state == stp_pkg::ST_SEND)
    else $error("startup announcement order wrong");
endmodule // stp_command_port

// File: hdl/stp_params.svh
`ifndef STP_PARAMS_SVH
`define STP_PARAMS_SVH
// Timing
`define STP_CLK_HZ      32'h05f5e100
`define STP_BAUD        32'h00002580
`define STP_MS_PER_S    32'h000003e8
`define STP_BIT_CYCLES  (`STP_CLK_HZ / `STP_BAUD)
`define STP_MS_CYCLES   (`STP_CLK_HZ / `STP_MS_PER_S)
`define STP_MINUTE_MS   16'hea60
// Register byte offsets
`define STP_OFF_CTRL    8'h00
`define STP_OFF_STATION 8'h04
`define STP_OFF_RDELAY  8'h08
`define STP_OFF_AUTOPER 8'h0c
`define STP_OFF_DATA    8'h10
`define STP_OFF_STATUS  8'h14
// Reset values and selections
`define STP_DPX_HALF    2'h0
`define STP_DPX_BUS     2'h1
`define STP_DPX_P2P     2'h2
`define STP_RST_DUPLEX  2'h1
`define STP_RST_STATION 7'h00
`define STP_BAUD_SEL    17'h00005
`define STP_MAX_STATION 17'h00063
`define STP_MAX_U16     17'h0ffff
// Characters
`define STP_CR          8'h0d
`define STP_BANG        8'h21
`define STP_ZERO        8'h30
`define STP_NINE        8'h39
// Command codes
`define STP_CMD_DUPLEX  16'h444d
`define STP_CMD_TERM    16'h4254
`define STP_CMD_PINSTN  16'h5849
`define STP_CMD_BAUD    16'h4252
`define STP_CMD_STNID   16'h4944
`define STP_CMD_TREQ    16'h5452
`define STP_CMD_TAUTO   16'h5454
`define STP_CMD_ERROR   16'h4345
// Error reasons
`define STP_ERR_ACCESS   6'h08
`define STP_ERR_RANGE    6'h10
`define STP_ERR_CONFLICT 6'h20
// Telegram lengths
`define STP_LEN_QUERY   4'h4
`define STP_LEN_SET     4'h9
`define STP_LEN_OVF     4'ha
`define STP_LEN_ACK     4'hb
`define STP_LEN_DATA    4'h8
`endif

// File: hdl/stp_pkg.sv
package stp_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SEND} stp_state_t;

  typedef struct packed {
    logic [2:0]  sync;
    logic        line;
    logic        busy;
    logic [13:0] cnt;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic        valid;
    logic [7:0]  data;
  } stp_rx_t;

  typedef struct packed {
    logic        busy;
    logic [13:0] cnt;
    logic [3:0]  bitn;
    logic [8:0]  sh;
    logic        txd;
  } stp_tx_t;

  typedef struct packed {
    stp_state_t        state;
    logic [0:8][7:0]   rxbuf;
    logic [3:0]        rxcnt;
    logic [0:10][7:0]  txbuf;
    logic [3:0]        txlen;
    logic [3:0]        txidx;
    logic              tx_start;
    logic              auto_tx;
    logic [1:0]        boot;
    logic [16:0]       ms_cnt;
    logic [15:0]       dly_ms;
    logic [15:0]       min_ms;
    logic              min_done;
    logic [15:0]       auto_ms;
    logic [1:0]        duplex;
    logic              term;
    logic              pin_en;
    logic [6:0]        station;
    logic [6:0]        ps0;
    logic [6:0]        ps1;
    logic [6:0]        ps2;
    logic [6:0]        pin_val;
    logic [15:0]       reply_dly;
    logic [15:0]       auto_per;
    logic [16:0]       data_val;
    logic [5:0]        last_err;
    logic              wr_pend;
    logic [7:0]        wr_addr;
    logic [31:0]       hrdata;
    logic              oe_n;
    logic              term_out;
  } stp_top_t;
endpackage

// File: hdl/stp_uart_rx.sv
`include "stp_params.svh"
module stp_uart_rx #(
  parameter int unsigned BIT_CYCLES = `STP_BIT_CYCLES
) (
  input  wire logic       hclk,     // System clock
  input  wire logic       hresetn,  // Async reset, active low
  input  wire logic       rxd,      // Serial line, asynchronous
  output logic            rx_valid, // One-cycle pulse per byte
  output logic [7:0]      rx_byte   // Received byte
);
  stp_pkg::stp_rx_t st;
  stp_pkg::stp_rx_t n;

  always_comb begin
    n = st;
    n.valid = 1'b0;
    n.sync = {st.sync[1], st.sync[0], rxd};
    if (st.sync[1] == st.sync[2]) begin
      n.line = st.sync[2];
    end
    if (!st.busy) begin
      if (!st.line) begin
        n.busy = 1'b1;
        n.cnt  = 14'(BIT_CYCLES / 2);
        n.bitn = 4'h0;
      end
    end else if (st.cnt != 14'h0) begin
      n.cnt = st.cnt - 14'h1;
    end else begin
      n.cnt = 14'(BIT_CYCLES - 1);
      if (st.bitn == 4'h0) begin
        // Glitch shorter than half a bit is not a start bit
        if (st.line) n.busy = 1'b0;
        else n.bitn = 4'h1;
      end else if (st.bitn <= 4'h8) begin
        n.sh   = {st.line, st.sh[7:1]};
        n.bitn = st.bitn + 4'h1;
      end else begin
        n.busy = 1'b0;
        if (st.line) begin
          n.valid = 1'b1;
          n.data  = st.sh;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) st <= '{sync: 3'h7, line: 1'b1, default: '0};
    else st <= n;
  end

  assign rx_valid = st.valid;
  assign rx_byte  = st.data;
endmodule // stp_uart_rx

// File: hdl/stp_uart_tx.sv
`include "stp_params.svh"
module stp_uart_tx #(
  parameter int unsigned BIT_CYCLES = `STP_BIT_CYCLES
) (
  input  wire logic       hclk,     // System clock
  input  wire logic       hresetn,  // Async reset, active low
  input  wire logic       tx_start, // Start a byte, idle only
  input  wire logic [7:0] tx_byte,  // Byte to send
  output logic            tx_busy,  // High until stop bit ends
  output logic            txd       // Serial line, idle high
);
  stp_pkg::stp_tx_t st;
  stp_pkg::stp_tx_t n;

  always_comb begin
    n = st;
    if (!st.busy) begin
      if (tx_start) begin
        n.busy = 1'b1;
        n.txd  = 1'b0;
        n.sh   = {1'b1, tx_byte};
        n.bitn = 4'h0;
        n.cnt  = 14'(BIT_CYCLES - 1);
      end
    end else if (st.cnt != 14'h0) begin
      n.cnt = st.cnt - 14'h1;
    end else if (st.bitn == 4'h9) begin
      n.busy = 1'b0;
    end else begin
      n.txd  = st.sh[0];
      n.sh   = {1'b1, st.sh[8:1]};
      n.bitn = st.bitn + 4'h1;
      n.cnt  = 14'(BIT_CYCLES - 1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) st <= '{txd: 1'b1, default: '0};
    else st <= n;
  end

  assign tx_busy = st.busy;
  assign txd     = st.txd;
endmodule // stp_uart_tx

// File: verif/serial_telegram_command_port_tb.sv
module serial_telegram_command_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BC = 16;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        rxd, txd, txd_oe_n, term_en;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [6:0]  pin_station;
  int          failures, checked, n;
  string       s;

  stp_command_port #(.BIT_CYCLES(BC), .MS_CYCLES(50)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd),
    .pin_station(pin_station), .txd(txd), .txd_oe_n(txd_oe_n), .term_en(term_en));

  stp_host_model #(.BIT_CYCLES(BC)) host (
    .hclk(hclk), .txd(txd), .txd_oe_n(txd_oe_n), .rxd(rxd));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic finish_test();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_str(input string got, input string exp);
    checked++;
    if (got != exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Empty expectation means silence over a fixed listening span
  task automatic cmd(input string tx, input string exp);
    host.rxq.delete();
    host.send(tx);
    s = "";
    n = 0;
    while (host.rxq.size() < exp.len() && n < 4000) begin
      @(posedge hclk);
      n++;
    end
    if (exp.len() == 0)
      repeat (800) @(posedge hclk);
    foreach (host.rxq[i]) s = {s, string'(host.rxq[i])};
    check_str(s, exp);
    repeat (2 * BC) @(posedge hclk);
  endtask

  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    pin_station = 7'h00;
    failures = 0;
    checked = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    cmd("", "!00BR00005\015!00DM00001\015");
    ahb(1'b0, 8'h00, 32'h0);
    check32(rd, 32'h1);
    check32({30'h0, hreadyout, hresp}, 32'h2);
    ahb(1'b0, 8'h04, 32'h0);
    check32(rd, 32'h0);
    check32({31'h0, txd_oe_n}, 32'h1);
    cmd("x\01500XI00001\015", "!00CE00032\015");
    cmd("00DM00003\015", "!00CE00016\015");
    cmd("00BR00003\015", "!00CE00008\015");
    cmd("05DM\015", "");
    ahb(1'b1, 8'h04, 32'h64);
    ahb(1'b0, 8'h04, 32'h0);
    check32(rd, 32'h0);
    ahb(1'b1, 8'h04, 32'h7);
    cmd("07DM\015", "!07DM00001\015");
    ahb(1'b1, 8'h04, 32'h0);
    cmd("00ID00003\015", "!03ID00003\015");
    ahb(1'b0, 8'h04, 32'h0);
    check32(rd, 32'h3);
    ahb(1'b1, 8'h04, 32'h0);
    ahb(1'b1, 8'h10, 32'h3039);
    cmd("00TR\015", "0012345\015");
    cmd("00DM00002\015", "!00DM00002\015");
    check32({31'h0, txd_oe_n}, 32'h0);
    cmd("00DM00000\015", "!00DM00000\015");
    check32({31'h0, txd_oe_n}, 32'h1);
    cmd("00BT00001\015", "!00BT00001\015");
    check32({31'h0, term_en}, 32'h1);
    pin_station <= 7'h0c;
    cmd("00XI00001\015", "!12XI00001\015");
    cmd("12XI00000\015", "!00XI00000\015");
    ahb(1'b1, 8'h08, 32'h4);
    host.rxq.delete();
    host.send("00DM\015");
    n = 0;
    while (host.line === 1'b1 && n < 1000) begin
      @(posedge hclk);
      n++;
    end
    check32(32'(n >= 190 && n < 240), 32'h1);
    check32({31'h0, txd_oe_n}, 32'h0);
    cmd("", "!00DM00000\015");
    cmd("00TT00002\015", "0012345\015");
    // Half duplex holds autosend for a minute after the setting
    cmd("", "");
    cmd("00DM00001\015", "!00DM00001\015");
    cmd("", "0012345\015");
    finish_test();
  end

  initial begin
    #900000;
    failures++;
    finish_test();
  end
endmodule // serial_telegram_command_port_tb

// File: verif/stp_host_model.sv
module stp_host_model #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic hclk,     // Bench clock
  input  wire logic txd,      // Device transmit line
  input  wire logic txd_oe_n, // Device driver enable, low drives
  output logic      rxd       // Host line toward the device
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rxq[$];
  logic [7:0] c;
  logic       line;

  // Released driver leaves the biased pair at mark
  assign line = txd_oe_n ? 1'b1 : txd;
  initial rxd = 1'b1;

  // Frames go out as start, eight data bits LSB first, stop
  task automatic send(input string s);
    logic [9:0] f;
    foreach (s[i]) begin
      f = {1'b1, s[i], 1'b0};
      for (int b = 0; b < 10; b++) begin
        rxd <= f[b];
        repeat (BIT_CYCLES) @(posedge hclk);
      end
    end
  endtask

  always begin
    @(negedge line);
    repeat (BIT_CYCLES / 2) @(posedge hclk);
    for (int b = 0; b < 8; b++) begin
      repeat (BIT_CYCLES) @(posedge hclk);
      c[b] = line;
    end
    rxq.push_back(c);
    repeat (BIT_CYCLES) @(posedge hclk);
  end
endmodule // stp_host_model
